/* core/pst_pkg.sv */
// Package: constants and carriers for the protection stage pick-up timer
package pst_pkg;
    // Measurement and setting widths
    localparam int MEAS_W = 18;  // Secondary current in mA, 1..250000
    localparam int PU_W = 12;  // Pick-up level in 0.01 per unit
    localparam int NOM_W = 14;  // Nominal current in mA
    localparam int DEF_W = 19;  // Definite delay in 5 ms steps
    localparam int DIAL_W = 12;  // Time dial in 0.01 s steps
    localparam int BASE_W = 20;  // Curve delay at unit dial, in ms
    localparam int TMR_W = 40;  // Operating timer in microseconds
    localparam int FLT_W = 3;  // Fault type code
    // Measurement span in mA
    localparam logic [MEAS_W-1:0] MEAS_MIN = 18'h00001;
    localparam logic [MEAS_W-1:0] MEAS_MAX = 18'h3D090;
    // Nominal current span in mA (0.2 A to 10 A)
    localparam logic [NOM_W-1:0] NOM_MIN = 14'h00C8;
    localparam logic [NOM_W-1:0] NOM_MAX = 14'h2710;
    // Release ratio in percent and its base
    localparam logic [6:0] REL_PCT = 7'h61;
    localparam logic [6:0] PCT_BASE = 7'h64;
    // Step sizes in milliseconds and their microsecond scale factors
    localparam int DEF_STEP_MS = 5;
    localparam int DIAL_STEP_MS = 10;
    localparam int US_PER_MS = 1000;
    localparam logic [12:0] DEF_STEP_US = 13'(DEF_STEP_MS * US_PER_MS);
    localparam logic [3:0] DIAL_STEP_US = 4'(DIAL_STEP_MS * US_PER_MS / 1000);
    // Reset defaults of the settings
    localparam logic [DEF_W-1:0] DEF_DELAY_RST = 19'h00008;  // 0.040 s
    localparam logic [DIAL_W-1:0] DIAL_RST = 12'h005;  // 0.05 s
    localparam logic [DIAL_W-1:0] DIAL_MIN = 12'h001;
    localparam logic [PU_W-1:0] PU_RST = 12'h064;  // 1.00 pu
    localparam logic [NOM_W-1:0] NOM_RST = 14'h03E8;  // 1 A
    // Stage states, one-hot
    typedef enum logic [3:0] {
        PST_IDLE = 4'h1,
        PST_START = 4'h2,
        PST_TRIP = 4'h4,
        PST_BLOCKED = 4'h8
    } pst_state_t;
    // Operator settings
    typedef struct packed {
        logic inverse_delay_mode;  // Low selects fixed_delay_mode
        logic curve_ieee;  // Low selects the IEC family
        logic [DEF_W-1:0] def_delay;
        logic [DIAL_W-1:0] dial;
        logic [PU_W-1:0] pickup_level;
        logic [NOM_W-1:0] nominal;
    } pst_cfg_t;
    // Block event record
    typedef struct packed {
        logic [MEAS_W-1:0] current;
        logic [FLT_W-1:0] fault;
    } pst_evt_t;
    localparam pst_cfg_t CFG_RST = '{1'b0, 1'b0, DEF_DELAY_RST, DIAL_RST,
        PU_RST, NOM_RST};
endpackage : pst_pkg

/* core/pst_stage_timer.sv */
// Protection stage: pick-up, blocking and trip timing in one module
// Functional notes
// - Compare measured magnitude against pick-up level at each program cycle strobe
// - Release pick-up below 97 percent of setting
// - Sample blocking input at each program cycle start
// - Unblocked pick-up asserts start, starts timing
// - Blocked pick-up shows blocked, suppresses start, trip
// - Block after start drops start, releases timing
// - Blocking issues display and stamped block event
// - Instantaneous mode trips together with start
// - Fixed mode trips after delay, pick-up held
// - Inverse mode delay follows setting to measurement
// - Inverse trip never before minimum; zero disables
// - Delay type selector, fixed mode after reset
// - Fixed delay in 5 ms steps, 40 ms default
// - Zero fixed delay means instantaneous operation
// - Curve family IEC or IEEE, inverse only
// - Nominal current 0.2 to 10 A as base
// - Measurement spans 0.001 A to 250 A
// - Time dial scales curve, 0.01 s steps
module pst_stage_timer #(
    parameter logic [15:0] CYC_US = 16'h03E8  // Program cycle length in us
) (
    // Clock, reset and enable
    input wire logic clk,
    input wire logic rst_b,
    input wire logic clk_en,
    // Program cycle strobe
    input wire logic cycle_tick,
    // Measurement path
    input wire logic [pst_pkg::MEAS_W-1:0] measured_magnitude,
    input wire logic [pst_pkg::FLT_W-1:0] fault_type,
    // Curve evaluator answer: delay at unit dial, in ms
    input wire logic [pst_pkg::BASE_W-1:0] curve_base_ms,
    // Settings and their load strobe
    input wire pst_pkg::pst_cfg_t cfg_in,
    input wire logic cfg_load,
    // Blocking matrix input
    input wire logic block_in,
    // Stage indications
    output logic pickup_o,
    output logic start_o,
    output logic trip_o,
    output logic blocked_o,
    output logic setting_fault_o,
    // Curve evaluator request
    output logic curve_active_o,
    output logic curve_ieee_o,
    // Event outputs
    output logic hmi_event_o,
    output logic block_event_o,
    output pst_pkg::pst_evt_t event_rec_o
);
    import pst_pkg::*;

    // One evaluation runs per program cycle strobe; between strobes state,
    // pick-up and timer hold, while the event pulse lasts one clock and the
    // setting outputs follow a load. Settings load on any enabled edge and
    // act at once, so a load in mid-timing moves the goal of the running timer.
    // The curve shape is computed outside this block and arrives as a
    // delay at unit dial; this block only scales it and applies the floor.
    // The timer counts microseconds so that the program cycle length and
    // the 5 ms setting step need no common divisor.
    // Blocking is read at the evaluating edge itself, which places it at
    // the start of that cycle's processing.

    pst_cfg_t cfg_ff;  // Active settings
    pst_state_t state_ff;  // Stage state
    pst_state_t nxt_state;
    logic pu_ff;  // Pick-up element
    logic block_ff;  // Block level seen at the last cycle start
    logic [TMR_W-1:0] timer_ff;  // Elapsed operating time in us
    logic [TMR_W-1:0] nxt_timer;
    logic evt_ff;  // Event pulse
    pst_evt_t evt_rec_ff;  // Event record

    // Measurement clamped to the representable span
    wire logic [MEAS_W-1:0] meas_c;
    assign meas_c = (measured_magnitude < MEAS_MIN) ? MEAS_MIN :
        (measured_magnitude > MEAS_MAX) ? MEAS_MAX :
        measured_magnitude;

    // Nominal clamped to its range; out of range is flagged
    wire logic nom_bad;
    wire logic [NOM_W-1:0] nom_c;
    assign nom_bad = (cfg_ff.nominal < NOM_MIN) || (cfg_ff.nominal > NOM_MAX);
    assign nom_c = (cfg_ff.nominal < NOM_MIN) ? NOM_MIN :
        (cfg_ff.nominal > NOM_MAX) ? NOM_MAX : cfg_ff.nominal;

    // Both sides scaled by 100 so the per-unit setting needs no divide
    wire logic [31:0] lvl_x100;
    wire logic [31:0] meas_x100;
    wire logic [38:0] lvl_rel;
    wire logic [38:0] meas_rel;
    assign lvl_x100 = 32'(cfg_ff.pickup_level) * 32'(nom_c);
    assign meas_x100 = 32'(meas_c) * 32'(PCT_BASE);
    assign lvl_rel = 39'(lvl_x100) * 39'(REL_PCT);
    assign meas_rel = 39'(meas_x100) * 39'(PCT_BASE);

    // Pick-up comparison and hysteresis band
    wire logic over_lvl;
    wire logic below_rel;
    wire logic nxt_pu;
    assign over_lvl = meas_x100 > lvl_x100;
    assign below_rel = meas_rel < lvl_rel;
    assign nxt_pu = pu_ff ? !below_rel : over_lvl;

    // One evaluation per program cycle, frozen by the enable
    wire logic eval;
    assign eval = clk_en && cycle_tick;

    // Delay targets in microseconds
    wire logic [TMR_W-1:0] def_us;
    wire logic [TMR_W-1:0] inv_us;
    wire logic [DIAL_W-1:0] dial_c;
    wire logic [TMR_W-1:0] target_us;
    wire logic instant;
    assign def_us = TMR_W'(cfg_ff.def_delay) * TMR_W'(DEF_STEP_US);
    assign dial_c = (cfg_ff.dial < DIAL_MIN) ? DIAL_MIN : cfg_ff.dial;
    // Curve value times dial; the curve itself comes from outside
    assign inv_us = TMR_W'(curve_base_ms) * TMR_W'(dial_c) *
        TMR_W'(DIAL_STEP_US);
    // Minimum floor; a zero floor leaves the curve alone
    assign target_us = (inv_us < def_us) ? def_us : inv_us;
    assign instant = !cfg_ff.inverse_delay_mode &&
        (cfg_ff.def_delay == '0);

    // Timer value after one more program cycle
    wire logic [TMR_W-1:0] timer_inc;
    wire logic [TMR_W-1:0] goal_us;
    wire logic timer_done;
    assign timer_inc = timer_ff + TMR_W'(CYC_US);
    assign goal_us = cfg_ff.inverse_delay_mode ? target_us :
        def_us;
    // Ratio only matters through the target, not through the timer
    assign timer_done = timer_inc >= goal_us;

    // Blocking is taken from the port in the evaluating cycle itself
    wire logic blk;
    assign blk = block_in;

    // Next state and timer
    always_comb begin
        nxt_state = state_ff;
        nxt_timer = timer_ff;
        // Defaults hold state and timer when no branch moves them
        case (state_ff)
            PST_IDLE: begin
                // Idle keeps the timer cleared for the next start
                nxt_timer = '0;
                if (nxt_pu && blk) begin
                    nxt_state = PST_BLOCKED;
                end else if (nxt_pu && instant) begin
                    nxt_state = PST_TRIP;
                end else if (nxt_pu) begin
                    nxt_state = PST_START;
                end
            end
            PST_START: begin
                // Release and block both abandon the running time
                if (blk || !nxt_pu) begin
                    // Block behaves as a pick-up release
                    nxt_state = PST_IDLE;
                    nxt_timer = '0;
                end else if (timer_done) begin
                    nxt_state = PST_TRIP;
                    nxt_timer = timer_inc;
                end else begin
                    nxt_timer = timer_inc;
                end
            end
            PST_TRIP: begin
                // Trip holds while picked up; a late block drops it
                if (blk || !nxt_pu) begin
                    nxt_state = PST_IDLE;
                    nxt_timer = '0;
                end
            end
            PST_BLOCKED: begin
                // No further processing until the pick-up releases
                if (!nxt_pu) begin
                    nxt_state = PST_IDLE;
                end
            end
            default: begin
                // Illegal codes fall back to a safe idle stage
                nxt_state = PST_IDLE;
                nxt_timer = '0;
            end
        endcase
    end

    // Event fires on any blocking of a picked-up stage
    wire logic blk_hit;
    assign blk_hit = eval && blk && nxt_pu &&
        (state_ff != PST_BLOCKED);

    // Settings register with reset defaults
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cfg_ff <= CFG_RST;
        end else if (clk_en && cfg_load) begin
            cfg_ff <= cfg_in;
        end
    end

    // Pick-up, block sample and state
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pu_ff <= 1'b0;
            block_ff <= 1'b0;
            state_ff <= PST_IDLE;
            timer_ff <= '0;
        end else if (eval) begin
            pu_ff <= nxt_pu;
            block_ff <= block_in;
            state_ff <= nxt_state;
            timer_ff <= nxt_timer;
        end
    end

    // Block event pulse and record of current and fault type
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            evt_ff <= 1'b0;
            evt_rec_ff <= '0;
        end else if (clk_en) begin
            evt_ff <= blk_hit;
            if (blk_hit) begin
                evt_rec_ff <= '{meas_c, fault_type};
            end
        end
    end

    // Indications straight from state flops; setting fault decoded from the settings register
    assign pickup_o = pu_ff;
    assign start_o = (state_ff == PST_START) || (state_ff == PST_TRIP);
    assign trip_o = state_ff == PST_TRIP;
    assign blocked_o = state_ff == PST_BLOCKED;
    assign setting_fault_o = nom_bad;
    // Family select only reaches the evaluator in inverse mode
    assign curve_active_o = cfg_ff.inverse_delay_mode;
    assign curve_ieee_o = cfg_ff.inverse_delay_mode &&
        cfg_ff.curve_ieee;
    assign hmi_event_o = evt_ff;
    assign block_event_o = evt_ff;
    assign event_rec_o = evt_rec_ff;
    // A block that comes late drops start and trip and returns the stage to idle

    // All checks run on the system clock and rest during reset
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    // Trip is only ever a phase of start, never of a blocked stage
    a_trip_with_start: assert property (
        trip_o |-> start_o && !blocked_o)
        else $error("trip without start");
    // A blocked pick-up stays silent into the following cycle
    a_blocked_silent: assert property (
        eval && state_ff == PST_IDLE && nxt_pu && block_in
        |=> blocked_o && !start_o && !trip_o ##1 !start_o && !trip_o)
        else $error("blocked stage not silent");
    // An unblocked crossing starts the stage on the same evaluation
    a_start_unblocked: assert property (
        eval && state_ff == PST_IDLE && over_lvl && !block_in
        |=> start_o && pickup_o)
        else $error("start missing");
    // Instantaneous operation raises trip together with start
    a_instant_trip: assert property (
        eval && state_ff == PST_IDLE && nxt_pu && !block_in && instant
        |=> trip_o && start_o)
        else $error("instant trip late");
    // A late block acts like a pick-up release
    a_late_block_drop: assert property (
        eval && start_o && block_in |=> !start_o && timer_ff == '0)
        else $error("start kept under block");
    // Inside the hysteresis band the pick-up holds
    a_hyst_hold: assert property (
        eval && pu_ff && !below_rel |=> pu_ff)
        else $error("pick-up released early");
    // Blocking a started stage raises one event pulse
    a_block_event: assert property (
        eval && state_ff == PST_START && block_in && nxt_pu
        |=> hmi_event_o && block_event_o ##1 !block_event_o || eval)
        else $error("block event missing");
    // Release before trip clears the operating timer
    a_timer_clear: assert property (
        eval && state_ff == PST_START && !nxt_pu |=> timer_ff == '0)
        else $error("timer kept on release");
    // Fixed mode trips only after the full fixed delay
    a_fixed_time: assert property (
        $rose(trip_o) && !cfg_ff.inverse_delay_mode && !instant
        |-> timer_ff >= def_us && $past(start_o))
        else $error("fixed trip early");
    // Inverse mode never trips under the minimum floor
    a_inverse_floor: assert property (
        $rose(trip_o) && cfg_ff.inverse_delay_mode |-> timer_ff >= def_us)
        else $error("inverse trip under floor");
    // Family select is inert outside inverse mode
    a_iec_default: assert property (
        !cfg_ff.inverse_delay_mode |-> !curve_ieee_o)
        else $error("family select outside inverse");
    // Block level is captured at every evaluation edge
    a_block_sample: assert property (
        eval |=> block_ff == $past(block_in))
        else $error("block sample lost");
    // Falling below the release band drops the pick-up
    a_release_idle: assert property (
        eval && pu_ff && below_rel |=> !pickup_o)
        else $error("pick-up held below band");
    // Each unblocked evaluation in start adds one program cycle
    a_timer_step: assert property (
        eval && state_ff == PST_START && nxt_pu && !block_in
        |=> timer_ff == $past(timer_inc))
        else $error("timer step wrong");
    // An idle stage holds no elapsed time
    a_idle_timer_zero: assert property (
        state_ff == PST_IDLE |-> timer_ff == '0)
        else $error("idle timer not zero");
    // The record holds the clamped current and fault of the hit
    a_event_record: assert property (
        clk_en && blk_hit |=> event_rec_o.current == $past(meas_c) &&
        event_rec_o.fault == $past(fault_type))
        else $error("event record wrong");
    // A delayed stage never trips on the evaluation that starts it
    a_delayed_no_trip: assert property (
        eval && state_ff == PST_IDLE && nxt_pu && !block_in && !instant
        |=> !trip_o)
        else $error("delayed stage tripped at once");
    // A settings load lands on the enabled edge that takes it
    a_setting_load: assert property (
        clk_en && cfg_load |=> cfg_ff == $past(cfg_in))
        else $error("settings not loaded");
    // A low enable freezes the stage and its timer
    a_enable_freeze: assert property (
        !clk_en |=> $stable(state_ff) && $stable(timer_ff))
        else $error("state moved while frozen");

    // Main scenarios worth seeing at least once
    c_trip: cover property ($rose(trip_o));
    c_blocked: cover property ($rose(blocked_o));
    c_late_block: cover property (start_o && !trip_o ##1 blocked_o || !start_o);
    c_inverse_trip: cover property ($rose(trip_o) && curve_active_o);
    c_hyst_hold: cover property (eval && pu_ff && !over_lvl && !below_rel);
endmodule : pst_stage_timer

/* verif/pst_far_model.sv */
// Far side model: measurement path, blocking matrix and curve evaluator
module pst_far_model (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Values requested by the bench
    input wire logic [pst_pkg::MEAS_W-1:0] want_ma,
    input wire logic [pst_pkg::FLT_W-1:0] want_fault,
    input wire logic want_block,
    input wire logic [pst_pkg::BASE_W-1:0] want_base,
    // Curve request from the stage
    input wire logic curve_active,
    // Values seen by the stage
    output logic [pst_pkg::MEAS_W-1:0] meas_ff,
    output logic [pst_pkg::FLT_W-1:0] fault_ff,
    output logic block_ff,
    output logic [pst_pkg::BASE_W-1:0] base_ff
);
    import pst_pkg::*;
    // Values move one edge after the bench asks, like a sampled path
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            meas_ff <= '0;
            fault_ff <= '0;
            block_ff <= 1'b0;
            base_ff <= '0;
        end else begin
            meas_ff <= want_ma;
            fault_ff <= want_fault;
            // Bench raises block well ahead of the operate delay
            block_ff <= want_block;
            // Idle evaluator shows a moving pattern, never a stale answer
            base_ff <= curve_active ? want_base : ~base_ff;
        end
    end
endmodule : pst_far_model

/* verif/testbench.sv */
// Testbench for the protection stage pick-up timer
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import pst_pkg::*;
    logic clk = 1'b0, rst_b = 1'b0, cycle_tick = 1'b0, cfg_load = 1'b0;
    pst_cfg_t cfg = CFG_RST, c;  // Settings driven and scratch copy
    logic [MEAS_W-1:0] want_ma = '0, meas;
    logic [FLT_W-1:0] want_fault = '0, fault;
    logic want_block = 1'b0, blk;
    logic [BASE_W-1:0] want_base = '0, base;
    logic pickup, start, trip, blocked, sfault, cact, cieee, hmi, bevt;
    pst_evt_t rec;
    int errors = 0, check_count = 0;
    // 4 ns clock
    always #2 clk = ~clk;
    pst_far_model i_far (.clk(clk), .rst_b(rst_b), .want_ma(want_ma),
        .want_fault(want_fault), .want_block(want_block),
        .want_base(want_base), .curve_active(cact), .meas_ff(meas),
        .fault_ff(fault), .block_ff(blk), .base_ff(base));
    pst_stage_timer i_dut (.clk(clk), .rst_b(rst_b), .clk_en(1'b1),
        .cycle_tick(cycle_tick), .measured_magnitude(meas),
        .fault_type(fault), .curve_base_ms(base), .cfg_in(cfg),
        .cfg_load(cfg_load), .block_in(blk), .pickup_o(pickup),
        .start_o(start), .trip_o(trip), .blocked_o(blocked),
        .setting_fault_o(sfault), .curve_active_o(cact),
        .curve_ieee_o(cieee), .hmi_event_o(hmi), .block_event_o(bevt),
        .event_rec_o(rec));
    // Compare one value and count it
    task chk(input logic [20:0] got, input logic [20:0] exp,
        input string what);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH t=%0t %s", $time, what);
        end
    endtask : chk
    // Load settings for one enabled edge
    task load(input pst_cfg_t v);
        @(posedge clk);
        #1 cfg = v;
        cfg_load = 1'b1;
        @(posedge clk);
        #1 cfg_load = 1'b0;
    endtask : load
    // Give n back-to-back evaluation strobes
    task tick(input int n);
        @(posedge clk);
        #1 cycle_tick = 1'b1;
        repeat (n) @(posedge clk);
        #1 cycle_tick = 0;
    endtask : tick
    // Start now, trip exactly k evaluations later
    task timed(input int k);
        tick(1);
        chk(start, 1'b1, "start missing");
        tick(k - 1);
        chk(trip, 1'b0, "trip early");
        tick(1);
        chk(trip, 1'b1, "trip late");
    endtask : timed
    // Drop the current and see the stage go quiet
    task release_all();
        want_ma = '0;
        want_block = 1'b0;
        tick(1);
        chk({pickup, start, trip, blocked}, 4'h0, "no release");
    endtask : release_all
    // Print counts and verdict, then stop
    task final_report();
        $display("Comparisons %0d, mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : final_report
    // Watchdog sized well above the whole sequence
    initial begin
        repeat (20000) @(posedge clk);
        errors++;
        $display("MISMATCH t=%0t watchdog expired", $time);
        final_report();
    end
    // Main sequence
    initial begin
        repeat (20) @(posedge clk);
        #1 rst_b = 1'b1;
        chk({start, trip, cact, sfault}, 4'h0, "reset state");
        want_ma = 18'd1000;
        tick(1);
        chk(pickup, 1'b0, "pickup at level");
        want_ma = 18'd1001;
        tick(1);
        chk(pickup, 1'b1, "no pickup above level");
        release_all();
        c = CFG_RST;
        c.def_delay = 19'h00002;
        load(c);
        want_ma = 18'd2000;
        timed(10);
        want_ma = 18'd980;
        tick(1);
        chk({pickup, trip}, 2'h3, "released above 97pct");
        want_ma = 18'd960;
        tick(1);
        chk({pickup, trip}, 2'h0, "held below 97pct");
        want_ma = 18'd2000;
        tick(5);
        release_all();
        want_ma = 18'd2000;
        timed(10);
        release_all();
        want_ma = 18'd2000;
        tick(3);
        want_block = 1'b1;
        want_fault = 3'h5;
        tick(1);
        chk({start, trip, hmi, bevt}, 4'h3, "late block");
        chk(rec, {18'd2000, 3'h5}, "event record");
        @(posedge clk);
        #1 chk({hmi, bevt}, 2'h0, "event not one cycle");
        want_block = 1'b0;
        timed(10);
        release_all();
        want_ma = 18'd3000;
        want_fault = 3'h2;
        want_block = 1'b1;
        tick(1);
        chk({blocked, start, hmi}, 3'h5, "blocked pickup");
        chk(rec, {18'd3000, 3'h2}, "blocked record");
        tick(15);
        chk({blocked, trip}, 2'h2, "blocked trip");
        release_all();
        c.def_delay = '0;
        load(c);
        want_ma = 18'd2000;
        tick(1);
        chk({start, trip}, 2'h3, "instant trip");
        release_all();
        c.def_delay = 19'h00002;
        c.inverse_delay_mode = 1'b1;
        c.curve_ieee = 1'b1;
        load(c);
        chk({cact, cieee}, 2'h3, "inverse select");
        want_base = 20'd400;
        want_ma = 18'd2000;
        timed(20);
        release_all();
        want_base = 20'd100;
        want_ma = 18'd2000;
        timed(10);
        release_all();
        c.def_delay = '0;
        load(c);
        want_ma = 18'd2000;
        timed(5);
        release_all();
        c.inverse_delay_mode = 1'b0;
        load(c);
        chk({cact, cieee}, 2'h0, "family outside inverse");
        c.nominal = 14'h00C7;
        load(c);
        chk(sfault, 1'b1, "nominal below span");
        c.nominal = 14'h00C8;
        load(c);
        chk(sfault, 1'b0, "nominal at low end");
        c.nominal = 14'h2711;
        load(c);
        chk(sfault, 1'b1, "nominal above span");
        final_report();
    end
endmodule : testbench
